// ### test/swdc_mem_model.sv
module swdc_mem_model (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic mem_req,
    input wire logic mem_excl,
    input wire logic dc_req,
    input wire logic grant,
    input wire logic [7:0] delay,
    output logic mem_ack,
    output logic mem_exokay,
    output logic dc_done
);
    timeunit 1ns;
    timeprecision 1ns;
    int xcnt;
    int dcnt;

    // Exclusive write answered after a chosen delay, slow or prompt
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            xcnt <= 0;
        else if (mem_req && mem_excl)
            xcnt <= delay + 1;
        else if (xcnt != 0)
            xcnt <= xcnt - 1;
    end

    // Outside the answer cycle the response shows the opposite value
    assign mem_ack = (xcnt == 1);
    assign mem_exokay = mem_ack ? grant : !grant;

    // Line work lasts delay + 1 cycles of dc_req, like a write-back of N beats
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst || !dc_req)
            dcnt <= 0;
        else
            dcnt <= dcnt + 1;
    end
    assign dc_done = dc_req && (dcnt == delay);
endmodule : swdc_mem_model

// ### test/test_swdc_store_unit.sv
module test_swdc_store_unit;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] RD = 32'hdead_beef;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic req_valid = 1'b0;
    logic reserving_load = 1'b0;
    logic [6:0] env_bits = '0; // user, virt, miss, ro, na, cache, grant
    logic [7:0] delay = 8'h02;
    swdc_pkg::swdc_req_s req = '0;
    swdc_pkg::swdc_req_s nreq;
    swdc_pkg::swdc_esr_s exception_status_reg, got_esr;
    logic [31:0] chk_addr, mem_addr, mem_data, dc_line_addr;
    logic req_ready, done, mode_wr, saved_user_mode, saved_virtual_mode;
    logic esr_wr, carry_wr, carry, mem_req, mem_excl, mem_ack, mem_exokay;
    logic dc_req, dc_flush, dc_match, dc_done, reservation, got_carry;
    logic [64:0] got_mem;
    logic [33:0] got_dc;
    logic [1:0] got_mode;
    logic [31:0] got_chk;
    int errors = 0;
    int samples_checked = 0;
    int n_mem, n_esr, n_mode, n_car, n_dc, lat;

    swdc_store_unit #(.PERIPH_EXCL(1'b1)) i_dut (.ref_clk(ref_clk),
        .sys_rst(sys_rst), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .done(done), .reservation(reservation),
        .reserving_load(reserving_load), .user_mode_bit(env_bits[6]),
        .virtual_mode_bit(env_bits[5]), .xlate_miss(env_bits[4]),
        .zone_read_only(env_bits[3]), .zone_no_access(env_bits[2]),
        .addr_is_cache(env_bits[1]), .chk_addr(chk_addr),
        .mode_wr(mode_wr), .saved_user_mode(saved_user_mode),
        .saved_virtual_mode(saved_virtual_mode), .esr_wr(esr_wr),
        .exception_status_reg(exception_status_reg), .carry_wr(carry_wr), .carry(carry), .mem_req(mem_req),
        .mem_excl(mem_excl), .mem_addr(mem_addr), .mem_data(mem_data),
        .mem_ack(mem_ack), .mem_exokay(mem_exokay), .dc_req(dc_req),
        .dc_flush(dc_flush), .dc_match(dc_match), .dc_done(dc_done),
        .dc_line_addr(dc_line_addr));

    swdc_mem_model i_far (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .mem_req(mem_req), .mem_excl(mem_excl), .dc_req(dc_req),
        .grant(env_bits[0]), .delay(delay), .mem_ack(mem_ack),
        .mem_exokay(mem_exokay), .dc_done(dc_done));

    always #50 ref_clk = ~ref_clk;

    // Record every pulse so a scenario can count and inspect them later
    always @(posedge ref_clk)
    begin
        n_mem += mem_req;
        n_esr += esr_wr;
        n_mode += mode_wr;
        n_car += carry_wr;
        n_dc += dc_req && dc_done;
        if (mem_req)
            got_mem = {mem_excl, mem_addr, mem_data};
        if (esr_wr)
            got_esr = exception_status_reg;
        if (carry_wr)
            got_carry = carry;
        if (mode_wr)
            got_mode = {saved_user_mode, saved_virtual_mode};
        if (dc_req)
            got_dc = {dc_flush, dc_match, dc_line_addr};
        if (done)
            got_chk = chk_addr;
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [71:0] seen,
        input logic [71:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic counts(input int m, input int e, input int c);
        check("mem writes", n_mem, m);
        check("status writes", n_esr, e);
        check("carry writes", n_car, c);
    endtask : counts

    task automatic op_set(input swdc_pkg::swdc_op_e op,
        input logic [31:0] ra, input logic [31:0] rb, input logic [15:0] im);
        nreq = '0;
        nreq.op = op;
        nreq.ra = ra;
        nreq.rb = rb;
        nreq.imm = im;
        nreq.rd = RD;
        nreq.rd_idx = 5'h0b;
    endtask : op_set

    task automatic set_env(input logic [6:0] v);
        @(posedge ref_clk);
        env_bits <= v;
    endtask : set_env

    task automatic reserve;
        @(posedge ref_clk);
        reserving_load <= 1'b1;
        @(posedge ref_clk);
        reserving_load <= 1'b0;
        @(negedge ref_clk);
        check("reservation set", reservation, 1'b1);
    endtask : reserve

    // Offer one request, wait for done, then let the outputs land
    task automatic run_op;
        n_mem = 0;
        n_esr = 0;
        n_mode = 0;
        n_car = 0;
        n_dc = 0;
        @(posedge ref_clk);
        req_valid <= 1'b1;
        req <= nreq;
        @(negedge ref_clk);
        while (req_ready !== 1'b1)
            @(negedge ref_clk);
        @(posedge ref_clk);
        req_valid <= 1'b0;
        lat = 1;
        @(negedge ref_clk);
        while (done !== 1'b1 && lat < 60)
        begin
            lat++;
            @(negedge ref_clk);
        end
        // A missing finish counts against the run
        if (lat >= 60)
            errors++;
        repeat (5) @(negedge ref_clk);
    endtask : run_op

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_stores;
        op_set(swdc_pkg::SWDC_STORE_RR, 32'h1000_0000, 32'h0000_0024,
            16'h0000);
        run_op();
        check("store latency", lat, 1);
        counts(1, 0, 0);
        check("store", got_mem, {1'b0, 32'h1000_0024, RD});
        op_set(swdc_pkg::SWDC_STORE_IMM, 32'h0000_2000, 0, 16'hfff8);
        run_op();
        check("imm store", got_mem, {1'b0, 32'h0000_1ff8, RD});
        nreq.prefix_valid = 1'b1;
        nreq.prefix_hi = 16'h0001;
        run_op();
        check("prefix store", got_mem, {1'b0, 32'h0002_1ff8, RD});
        check("prefix address", got_chk, 32'h0002_1ff8);
    endtask : t_stores

    task automatic t_faults;
        op_set(swdc_pkg::SWDC_STORE_RR, 32'h0000_0100, 32'h0000_0002,
            16'h0000);
        run_op();
        counts(0, 1, 0);
        check("align", {got_esr.cause, got_esr.store, got_esr.word,
            got_esr.rx}, {swdc_pkg::CAUSE_ALIGN, 2'b11, 5'h0b});
        set_env(7'b1110100);
        run_op();
        counts(0, 1, 0);
        check("miss", {got_esr.cause, got_esr.store},
            {swdc_pkg::CAUSE_MISS, 1'b1});
        check("saved modes", {n_mode, got_mode}, {32'd1, 2'b11});
        set_env(7'b1100100);
        nreq.rb = 32'h0000_0004;
        run_op();
        check("zone", {n_esr, got_esr.cause, got_esr.store,
            got_esr.zone_fault_flag},
            {32'd1, swdc_pkg::CAUSE_ZONE, 2'b11});
        set_env(7'b0101100);
        run_op();
        check("priv zone", {got_esr.zone_fault_flag, got_mode},
            3'b001);
        set_env(7'b0001100);
        run_op();
        counts(1, 0, 0);
    endtask : t_faults

    task automatic t_cond;
        set_env(7'b1110000);
        op_set(swdc_pkg::SWDC_STORE_COND, 32'h0000_0200, 32'h0000_0003,
            16'h0000);
        run_op();
        counts(0, 0, 1);
        check("carry no res", got_carry, 1'b1);
        reserve();
        run_op();
        counts(0, 1, 0);
        check("res kept", reservation, 1'b1);
        set_env(7'b0000010);
        run_op();
        counts(1, 0, 1);
        check("cond store", got_mem, {1'b0, 32'h0000_0203, RD});
        check("carry ok", {got_carry, reservation}, 2'b00);
        // No carry consumer is issued right after a conditional store
        for (int g = 0; g < 2; g++)
        begin
            reserve();
            delay <= 8'(3 * g);
            set_env(7'(g));
            run_op();
            check("excl flag", got_mem[64], 1'b1);
            check("excl carry", {n_car, got_carry}, {32'd1, !g[0]});
        end
    endtask : t_cond

    task automatic t_tag;
        set_env(7'b0000000);
        for (int k = 0; k < 4; k++)
        begin
            op_set(swdc_pkg::SWDC_TAG_WRITE, 32'h3000_0004, 32'h0000_0018,
                16'h0000);
            {nreq.flush, nreq.match} = 2'(k);
            // Only a flush keeps the cache busy for write-back beats
            delay <= 8'(k & 2);
            run_op();
            check("tag count", n_dc, 1);
            check("tag latency", lat, k == 0 ? 3 : 2 + (k & 2));
            check("tag", got_dc,
                {2'(k), 32'h3000_0010});
        end
        set_env(7'b1000000);
        run_op();
        check("priv", {n_dc, n_esr, got_esr.cause},
            {32'd0, 32'd1, swdc_pkg::CAUSE_PRIV});
    endtask : t_tag

    task automatic tally_and_finish;
        $display("checked %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish

    // Main sequence after a two-cycle reset
    initial
    begin
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(negedge ref_clk);
        check("reservation reset", reservation, 1'b0);
        t_stores();
        t_faults();
        t_cond();
        t_tag();
        tally_and_finish();
    end

    // Watchdog well beyond the few hundred cycles the run needs
    initial
    begin
        #500_000;
        errors++;
        tally_and_finish();
    end
endmodule : test_swdc_store_unit

// ### verilog/swdc_pkg.sv
package swdc_pkg;
    localparam logic [4:0] CAUSE_MISS = 5'h12;
    localparam logic [4:0] CAUSE_ZONE = 5'h10;
    localparam logic [4:0] CAUSE_ALIGN = 5'h01;
    localparam logic [4:0] CAUSE_PRIV = 5'h07;
    localparam int LINE_LSB = 4;
    localparam logic [31:0] LINE_MASK = 32'hffff_fff0;
    localparam logic [1:0] ALIGN_MASK = 2'h0;

    typedef enum logic [2:0] {
        SWDC_NOP,
        SWDC_STORE_RR,
        SWDC_STORE_IMM,
        SWDC_STORE_COND,
        SWDC_TAG_WRITE
    } swdc_op_e;

    typedef struct packed {
        swdc_op_e op;
        logic flush;
        logic match;
        logic prefix_valid;
        logic [15:0] prefix_hi;
        logic [15:0] imm;
        logic [31:0] ra;
        logic [31:0] rb;
        logic [31:0] rd;
        logic [4:0] rd_idx;
    } swdc_req_s;

    typedef struct packed {
        logic [4:0] cause;
        logic store;
        logic word;
        logic zone_fault_flag;
        logic [4:0] rx;
    } swdc_esr_s;
endpackage : swdc_pkg

// ### verilog/swdc_store_unit.sv
// The implementer's own choices: the strobed register port.
module swdc_store_unit #(
    parameter bit AREA_OPT = 1'b0,
    parameter bit COPY_BACK = 1'b1,
    parameter bit PERIPH_EXCL = 1'b0,
    parameter bit CACHE_EXCL = 1'b0,
    parameter bit TRANSLATION = 1'b1
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic req_valid,
    input wire swdc_pkg::swdc_req_s req,
    output logic req_ready,
    output logic done,
    input wire logic reserving_load,
    input wire logic user_mode_bit,
    input wire logic virtual_mode_bit,
    input wire logic xlate_miss,
    input wire logic zone_read_only,
    input wire logic zone_no_access,
    input wire logic addr_is_cache,
    output logic [31:0] chk_addr,
    output logic mode_wr,
    output logic saved_user_mode,
    output logic saved_virtual_mode,
    output logic esr_wr,
    output swdc_pkg::swdc_esr_s exception_status_reg,
    output logic carry_wr,
    output logic carry,
    output logic mem_req,
    output logic mem_excl,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_data,
    input wire logic mem_ack,
    input wire logic mem_exokay,
    output logic dc_req,
    output logic dc_flush,
    output logic dc_match,
    output logic [31:0] dc_line_addr,
    input wire logic dc_done,
    output logic reservation
);
    // ------------------------------------------------------------
    // Operand decode
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WAIT,
        ST_MEM,
        ST_DC,
        ST_DONE
    } swdc_state_e;

    swdc_state_e state_ff;
    swdc_pkg::swdc_req_s req_ff;
    logic reservation_ff;
    logic [31:0] imm32;
    logic [31:0] eff_addr;
    logic is_store;
    logic miss_hit;
    logic zone_hit;
    logic align_hit;
    logic priv_hit;
    logic excl_used;
    logic dc_pending_ff;

    // Prefix supplies the upper half, else sign-extend
    always_comb
    begin
        if (req_ff.prefix_valid)
            imm32 = {req_ff.prefix_hi, req_ff.imm};
        else
            imm32 = {{16{req_ff.imm[15]}}, req_ff.imm};
    end

    // Address per form; write-through tag write ignores rB
    always_comb
    begin
        unique case (req_ff.op)
            swdc_pkg::SWDC_STORE_IMM: eff_addr = req_ff.ra + imm32;
            swdc_pkg::SWDC_TAG_WRITE:
                eff_addr = COPY_BACK ? req_ff.ra + req_ff.rb
                                     : req_ff.ra;
            default: eff_addr = req_ff.ra + req_ff.rb;
        endcase
    end

    assign chk_addr = eff_addr;
    assign is_store = req_ff.op == swdc_pkg::SWDC_STORE_RR
        || req_ff.op == swdc_pkg::SWDC_STORE_IMM;
    // ------------------------------------------------------------
    // Exception checks, in priority order
    // ------------------------------------------------------------
    assign miss_hit = virtual_mode_bit && xlate_miss;
    // No-access only counts in user mode
    assign zone_hit = virtual_mode_bit && !miss_hit
        && (zone_read_only || (zone_no_access && user_mode_bit));
    assign align_hit = is_store && !miss_hit && !zone_hit
        && (eff_addr[1:0] != swdc_pkg::ALIGN_MASK);
    assign priv_hit = TRANSLATION && user_mode_bit;
    // Exclusive use chosen per port
    assign excl_used = addr_is_cache ? CACHE_EXCL : PERIPH_EXCL;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    logic go;
    logic dc_quick;
    assign go = state_ff == ST_WAIT || (state_ff == ST_IDLE && !AREA_OPT
        && req_ff.op != swdc_pkg::SWDC_NOP);
    assign req_ready = state_ff == ST_IDLE && req_ff.op == swdc_pkg::SWDC_NOP;
    // Clear and flush finish on the cache answer, plain tag writes one later.
    // Limitation: the area option still puts its wait cycle in front.
    assign dc_quick = req_ff.flush || req_ff.match;

    // Request capture; one request in flight at a time
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            req_ff <= '0;
        else if (req_valid && req_ready)
            req_ff <= req;
        else if (done)
            req_ff <= '0;
    end

    // State register; the extra area cycle is ST_WAIT
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            state_ff <= ST_IDLE;
        else
        begin
            unique case (state_ff)
                ST_IDLE:
                    if (req_ff.op != swdc_pkg::SWDC_NOP)
                        state_ff <= AREA_OPT ? ST_WAIT : ST_IDLE;
                    else
                        state_ff <= ST_IDLE;
                ST_WAIT:
                    state_ff <= ST_IDLE;
                ST_MEM:
                    if (mem_ack)
                        state_ff <= ST_IDLE;
                ST_DC:
                    if (dc_done)
                        state_ff <= dc_quick ? ST_IDLE : ST_DONE;
                ST_DONE:
                    state_ff <= ST_IDLE;
            endcase
            if (go && req_ff.op == swdc_pkg::SWDC_STORE_COND && reservation_ff
                && !miss_hit && !zone_hit && excl_used)
                state_ff <= ST_MEM;
            if (go && req_ff.op == swdc_pkg::SWDC_TAG_WRITE && !priv_hit)
                state_ff <= ST_DC;
        end
    end

    // Completion pulse
    always_comb
    begin
        done = 1'b0;
        if (go && !(req_ff.op == swdc_pkg::SWDC_TAG_WRITE && !priv_hit)
            && !(req_ff.op == swdc_pkg::SWDC_STORE_COND && reservation_ff
                 && !miss_hit && !zone_hit && excl_used))
            done = 1'b1;
        if (state_ff == ST_MEM && mem_ack)
            done = 1'b1;
        if (state_ff == ST_DC && dc_done && dc_quick)
            done = 1'b1;
        if (state_ff == ST_DONE)
            done = 1'b1;
    end

    // ------------------------------------------------------------
    // Reservation bit
    // ------------------------------------------------------------
    // Load sets; a conditional store past checks clears. Set wins.
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            reservation_ff <= 1'b0;
        else if (reserving_load)
            reservation_ff <= 1'b1;
        else if (go && req_ff.op == swdc_pkg::SWDC_STORE_COND
                 && !miss_hit && !zone_hit)
            reservation_ff <= 1'b0;
    end
    assign reservation = reservation_ff;

    // ------------------------------------------------------------
    // Status and exception outputs
    // ------------------------------------------------------------
    // Registered outputs update once, in the finishing cycle
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            mode_wr <= 1'b0;
            saved_user_mode <= 1'b0;
            saved_virtual_mode <= 1'b0;
            esr_wr <= 1'b0;
            exception_status_reg <= '0;
            carry_wr <= 1'b0;
            carry <= 1'b0;
        end
        else
        begin
            mode_wr <= 1'b0;
            esr_wr <= 1'b0;
            carry_wr <= 1'b0;
            if (go && req_ff.op == swdc_pkg::SWDC_TAG_WRITE && priv_hit)
            begin
                esr_wr <= 1'b1;
                exception_status_reg <= '{swdc_pkg::CAUSE_PRIV, 1'b0, 1'b0, 1'b0, 5'h00};
            end
            else if (go && req_ff.op == swdc_pkg::SWDC_STORE_COND
                     && !reservation_ff)
            begin
                carry_wr <= 1'b1;
                carry <= 1'b1;
            end
            else if (go && req_ff.op != swdc_pkg::SWDC_TAG_WRITE
                     && (miss_hit || zone_hit))
            begin
                // Save modes, core clears live bits on mode_wr
                mode_wr <= 1'b1;
                saved_user_mode <= user_mode_bit;
                saved_virtual_mode <= virtual_mode_bit;
                esr_wr <= 1'b1;
                exception_status_reg <= '{miss_hit ? swdc_pkg::CAUSE_MISS : swdc_pkg::CAUSE_ZONE,
                         1'b1, 1'b0, zone_hit && zone_no_access
                         && user_mode_bit, 5'h00};
            end
            else if (go && align_hit)
            begin
                esr_wr <= 1'b1;
                exception_status_reg <= '{swdc_pkg::CAUSE_ALIGN, 1'b1, 1'b1, 1'b0,
                         req_ff.rd_idx};
            end
            else if (go && req_ff.op == swdc_pkg::SWDC_STORE_COND && !excl_used)
            begin
                carry_wr <= 1'b1;
                carry <= 1'b0;
            end
            else if (state_ff == ST_MEM && mem_ack)
            begin
                carry_wr <= 1'b1;
                carry <= !mem_exokay;
            end
        end
    end

    // ------------------------------------------------------------
    // Memory and cache requests
    // ------------------------------------------------------------
    // Plain stores and reserved conditional stores write at once; mem_excl marks exclusive ones
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            mem_req <= 1'b0;
            mem_excl <= 1'b0;
            mem_addr <= '0;
            mem_data <= '0;
        end
        else
        begin
            mem_req <= 1'b0;
            mem_excl <= 1'b0;
            if (go && !miss_hit && !zone_hit && !align_hit
                && (is_store || (req_ff.op == swdc_pkg::SWDC_STORE_COND
                                 && reservation_ff)))
            begin
                mem_req <= 1'b1;
                mem_excl <= req_ff.op == swdc_pkg::SWDC_STORE_COND
                    && excl_used;
                mem_addr <= eff_addr;
                mem_data <= req_ff.rd;
            end
        end
    end

    // Tag write request held until the cache reports done
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            dc_pending_ff <= 1'b0;
            dc_flush <= 1'b0;
            dc_match <= 1'b0;
            dc_line_addr <= '0;
        end
        else if (go && req_ff.op == swdc_pkg::SWDC_TAG_WRITE && !priv_hit)
        begin
            dc_pending_ff <= 1'b1;
            dc_flush <= COPY_BACK && req_ff.flush;
            dc_match <= COPY_BACK && req_ff.match;
            dc_line_addr <= eff_addr & swdc_pkg::LINE_MASK;
        end
        else if (dc_done)
            dc_pending_ff <= 1'b0;
    end
    assign dc_req = dc_pending_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    miss_priority_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        go && is_store && virtual_mode_bit && xlate_miss
        |=> esr_wr && exception_status_reg.cause == swdc_pkg::CAUSE_MISS && !mem_req)
        else $error("miss not reported first");
    zone_cause_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        go && is_store && zone_hit
        |=> mode_wr && exception_status_reg.cause == swdc_pkg::CAUSE_ZONE)
        else $error("zone fault not reported");
    zone_flag_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        go && is_store && zone_hit && !user_mode_bit
        |=> esr_wr && !exception_status_reg.zone_fault_flag)
        else $error("no-access flag set in privileged mode");
    mode_save_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        go && is_store && miss_hit |=> saved_virtual_mode)
        else $error("virtual mode not saved");
    align_fault_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        go && align_hit |=> exception_status_reg.word && exception_status_reg.store && !mem_req)
        else $error("misaligned store not trapped");
    cond_no_align_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        go && req_ff.op == swdc_pkg::SWDC_STORE_COND
        |=> !(esr_wr && exception_status_reg.cause == swdc_pkg::CAUSE_ALIGN))
        else $error("conditional store raised misalignment");
    no_resv_carry_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        go && req_ff.op == swdc_pkg::SWDC_STORE_COND && !reservation_ff
        |=> carry_wr && carry && !mem_req)
        else $error("failed conditional store wrote");
    resv_clear_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        go && req_ff.op == swdc_pkg::SWDC_STORE_COND && !miss_hit
        && !zone_hit && !reserving_load |=> !reservation_ff)
        else $error("reservation left set");
    local_commit_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        go && req_ff.op == swdc_pkg::SWDC_STORE_COND && reservation_ff
        && !miss_hit && !zone_hit && !excl_used
        |=> mem_req && !mem_excl && carry_wr && !carry)
        else $error("reserved conditional store did not commit");
    excl_commit_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        state_ff == ST_MEM && mem_ack
        |=> carry_wr && carry == !$past(mem_exokay))
        else $error("exclusive answer not reflected in carry");
    store_latency_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        state_ff == ST_IDLE && is_store |-> AREA_OPT || done)
        else $error("store latency wrong");
    area_latency_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        state_ff == ST_IDLE && is_store && AREA_OPT |=> done)
        else $error("area store latency wrong");
    tag_latency_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        state_ff == ST_DC && dc_done && !dc_quick |=> done)
        else $error("plain tag write finish cycle wrong");
    priv_trap_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        go && req_ff.op == swdc_pkg::SWDC_TAG_WRITE && priv_hit
        |=> esr_wr && exception_status_reg.cause == swdc_pkg::CAUSE_PRIV && !dc_req)
        else $error("user tag write not trapped");
    wt_addr_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        go && req_ff.op == swdc_pkg::SWDC_TAG_WRITE && !COPY_BACK
        |-> eff_addr == req_ff.ra)
        else $error("write-through line address used rB");
    store_cov: cover property (@(posedge ref_clk) mem_req && !mem_excl);
    cond_cov: cover property (@(posedge ref_clk) carry_wr && !carry);
    dc_cov: cover property (@(posedge ref_clk) dc_req && dc_flush);
    fault_cov: cover property (@(posedge ref_clk) mode_wr);
    excl_cov: cover property (@(posedge ref_clk) state_ff == ST_MEM && mem_ack);
endmodule : swdc_store_unit
